//--- include/dfc_pkg.sv
`default_nettype none
package dfc_pkg;

    // ************************************************************
    // register map (word index, byte address = index * 4)
    // ************************************************************
    localparam logic [7:0]  REG_IDX_PHASE_DETECTOR  = 8'h0B;
    localparam logic [7:0]  REG_IDX_EXACT_FREQUENCY = 8'h0C;
    localparam logic [9:0]  ADDR_PHASE_DETECTOR     = {REG_IDX_PHASE_DETECTOR, 2'b00};
    localparam logic [9:0]  ADDR_EXACT_FREQUENCY    = {REG_IDX_EXACT_FREQUENCY, 2'b00};
    localparam int          REG_WIDTH               = 24;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [23:0] RESET_PHASE_DETECTOR    = 24'h0F_8061;
    localparam logic [23:0] RESET_EXACT_FREQUENCY   = 24'h00_0000;

    // ************************************************************
    // phase detector fields
    // ************************************************************
    localparam int          PD_DELAY_LSB            = 0;
    localparam int          PD_DELAY_MSB            = 2;
    localparam int          PD_RAISE_EN_BIT         = 5;
    localparam int          PD_LOWER_EN_BIT         = 6;
    localparam int          PD_GUARD_LSB            = 7;
    localparam int          PD_GUARD_MSB            = 8;
    localparam int          PD_RAISE_FORCE_BIT      = 9;
    localparam int          PD_LOWER_FORCE_BIT      = 10;
    localparam int          PD_PIN_LEVEL_BIT        = 22;

    // ************************************************************
    // exact frequency fields
    // ************************************************************
    localparam int          EXACT_COUNT_LSB         = 0;
    localparam int          EXACT_COUNT_MSB         = 13;
    localparam logic [13:0] EXACT_COUNT_MIN_ON      = 14'h0002;

    // cycle-slip thresholds in ps, for reference by users of the select code
    localparam int          GUARD_THRESH_1_PS       = 5400;
    localparam int          GUARD_THRESH_2_PS       = 14400;
    localparam int          GUARD_THRESH_3_PS       = 24100;

    typedef enum logic [1:0]
    {
        DFC_GUARD_OFF = 2'h0,
        DFC_GUARD_1   = 2'h1,
        DFC_GUARD_2   = 2'h2,
        DFC_GUARD_3   = 2'h3
    } dfc_guard_e;

endpackage
`default_nettype wire

//--- rtl/dfc_config_word.sv
`timescale 1ns/100ps
`default_nettype none
module dfc_config_word
#(
    parameter logic [23:0] RESET_VALUE = 24'h00_0000
)
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // write port
    input  wire logic        write_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [23:0] data_i,
    // stored value
    output logic      [23:0] value_o
);

    // three byte lanes; lane 3 has no storage
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            value_o <= RESET_VALUE;
        end
        else if (write_i)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (sel_i[i])
                begin
                    value_o[i*8 +: 8] <= data_i[i*8 +: 8];
                end
            end
        end
    end

endmodule
`default_nettype wire

//--- rtl/dfc_detector_exact_config.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - the phase-detector register keeps a 3-bit reset-path delay select in bits 2:0, reset to 1.
// - bit 5 enables the detector up output, default on.
// - bit 6 enables the detector down output, default on.
// - bits 8:7 choose the cycle-slip guard threshold, 0 off then 5.4, 14.4, 24.1 ns, default 0.
// - bit 9 forces the pump up output on, test use only, default 0.
// - bit 10 forces the pump down output on, test use only, default 0.
// - bit 22 picks the readback pin drive level, 0 for 1.8 V and 1 for 3.3 V, default 0.
// - the exact frequency register at index 0x0C resets to zero, leaving the mode off.
// - channel counts 0 and 1 leave exact mode off, counts 2 to 16383 switch it on.
module dfc_detector_exact_config
    import dfc_pkg::*;
(
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 reset_i,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [9:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    // detector controls
    input  wire logic                 detector_raise_i,
    input  wire logic                 detector_lower_i,
    output logic      [2:0]           detector_reset_delay_select_o,
    output logic                      pump_raise_o,
    output logic                      pump_lower_o,
    output var dfc_pkg::dfc_guard_e   cycle_slip_guard_select_o,
    output logic                      lock_or_readback_pin_level_o,
    // exact frequency mode
    output logic      [13:0]          exact_mode_channel_count_o,
    output logic                      exact_mode_enable_o
);
    import dfc_pkg::*;

    // ************************************************************
    // bus decode
    // ************************************************************
    logic        request;
    logic        hit_pd;
    logic        hit_exact;
    logic        write_pd;
    logic        write_exact;
    logic [23:0] phase_detector_config;
    logic [23:0] exact_frequency_config;

    // ack lasts one cycle; a request is ignored in the ack or err cycle only, so one held past it is taken again
    assign request     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_pd      = (wb_adr_i == ADDR_PHASE_DETECTOR);
    assign hit_exact   = (wb_adr_i == ADDR_EXACT_FREQUENCY);
    assign write_pd    = request && wb_we_i && hit_pd;
    assign write_exact = request && wb_we_i && hit_exact;

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= request && (hit_pd || hit_exact);
            wb_err_o <= request && !(hit_pd || hit_exact);
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (request && hit_pd)
        begin
            wb_dat_o <= {8'h00, phase_detector_config};
        end
        else if (request && hit_exact)
        begin
            wb_dat_o <= {8'h00, exact_frequency_config};
        end
        else
        begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // register storage
    // ************************************************************
    // default delay 1
    dfc_config_word #(
        .RESET_VALUE (RESET_PHASE_DETECTOR)
    ) u_phase_detector (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .write_i (write_pd),
        .sel_i   (wb_sel_i),
        .data_i  (wb_dat_i[23:0]),
        .value_o (phase_detector_config)
    );

    dfc_config_word #(
        .RESET_VALUE (RESET_EXACT_FREQUENCY)
    ) u_exact_frequency (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .write_i (write_exact),
        .sel_i   (wb_sel_i),
        .data_i  (wb_dat_i[23:0]),
        .value_o (exact_frequency_config)
    );

    // ************************************************************
    // detector outputs
    // ************************************************************
    // detector inputs come from same-clock logic, no sync
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pump_raise_o <= 1'b0;
            pump_lower_o <= 1'b0;
        end
        else
        begin
            pump_raise_o <= (detector_raise_i && phase_detector_config[PD_RAISE_EN_BIT])
                            || phase_detector_config[PD_RAISE_FORCE_BIT];
            pump_lower_o <= (detector_lower_i && phase_detector_config[PD_LOWER_EN_BIT])
                            || phase_detector_config[PD_LOWER_FORCE_BIT];
        end
    end

    assign detector_reset_delay_select_o = phase_detector_config[PD_DELAY_MSB:PD_DELAY_LSB];
    assign cycle_slip_guard_select_o     = dfc_guard_e'(phase_detector_config[PD_GUARD_MSB:PD_GUARD_LSB]);
    assign lock_or_readback_pin_level_o  = phase_detector_config[PD_PIN_LEVEL_BIT];

    // ************************************************************
    // exact frequency mode
    // ************************************************************
    assign exact_mode_channel_count_o = exact_frequency_config[EXACT_COUNT_MSB:EXACT_COUNT_LSB];

    // counts below 2 keep it off
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            exact_mode_enable_o <= 1'b0;
        end
        else
        begin
            exact_mode_enable_o <= (exact_frequency_config[EXACT_COUNT_MSB:EXACT_COUNT_LSB] >= EXACT_COUNT_MIN_ON);
        end
    end

endmodule
`default_nettype wire

//--- dv/dfc_props.sv
`timescale 1ns/100ps
`default_nettype none
module dfc_props
    import dfc_pkg::*;
(
    // clock and bus
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // controls
    input wire logic        detector_raise_i,
    input wire logic        detector_lower_i,
    input wire logic        pump_raise_o,
    input wire logic        pump_lower_o,
    input wire logic [2:0]  detector_reset_delay_select_o,
    input wire dfc_pkg::dfc_guard_e cycle_slip_guard_select_o,
    input wire logic        lock_or_readback_pin_level_o,
    input wire logic [13:0] exact_mode_channel_count_o,
    input wire logic        exact_mode_enable_o
);
    logic [9:0] adr_q;
    logic       rd_q;
    // request is held until ack, so last cycle's copy names the answered read
    wire        pd_rd = wb_ack_o && rd_q && adr_q == ADDR_PHASE_DETECTOR;
    always_ff @(posedge clock_i)
    begin
        adr_q <= wb_adr_i;
        rd_q  <= !wb_we_i;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_raise_force: assert property (pd_rd && wb_dat_o[9] |=> pump_raise_o)
        else $error("raise force");
    a_lower_force: assert property (pd_rd && wb_dat_o[10] |=> pump_lower_o)
        else $error("lower force");
    a_raise_gate: assert property (pd_rd && !wb_dat_o[9] |=>
        pump_raise_o == ($past(detector_raise_i) && $past(wb_dat_o[5]))) else $error("raise gate");
    a_lower_gate: assert property (pd_rd && !wb_dat_o[10] |=>
        pump_lower_o == ($past(detector_lower_i) && $past(wb_dat_o[6]))) else $error("lower gate");
    a_field_map: assert property (pd_rd |-> detector_reset_delay_select_o == wb_dat_o[2:0] &&
        cycle_slip_guard_select_o == wb_dat_o[8:7]) else $error("field map");
    a_level_map: assert property (pd_rd |-> lock_or_readback_pin_level_o == wb_dat_o[22])
        else $error("pin level");
    a_enable_count: assert property (1 |=> exact_mode_enable_o == ($past(exact_mode_channel_count_o) > 14'h0001))
        else $error("exact enable");
    a_exact_reset: assert property ($fell(reset_i) |-> exact_mode_channel_count_o == 14'h0000)
        else $error("exact reset");
    cover property (pd_rd && wb_dat_o[9]);
    cover property (pd_rd && wb_dat_o[6:5] == 2'h3);
    cover property ($rose(exact_mode_enable_o));
endmodule
bind dfc_detector_exact_config dfc_props u_props
(
    .clock_i, .reset_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .detector_raise_i, .detector_lower_i,
    .pump_raise_o, .pump_lower_o, .detector_reset_delay_select_o, .cycle_slip_guard_select_o,
    .lock_or_readback_pin_level_o, .exact_mode_channel_count_o, .exact_mode_enable_o
);
`default_nettype wire

//--- dv/dfc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dfc_host_model
(
    // bus answer
    input  wire logic        clock_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    input  wire logic [31:0] dat_i,
    // bus request
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [9:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // reserved at default, overrides only in test runs
    function automatic logic [31:0] legal(input logic [31:0] d);
        return {9'h0, d[22], 11'h1F0, d[10:5], 2'h0, d[2:0]};
    endfunction
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clock_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hF, d};
        do
            @(posedge clock_i);
        while (!(ack_i || err_i));
        q = dat_i;
        e = err_i;
        // released lines other than sel_o must not echo the last value
        {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h0, ~w, ~a, ~d};
    endtask
endmodule
`default_nettype wire

//--- dv/dfc_detector_exact_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dfc_detector_exact_config_tb;
    import dfc_pkg::*;
    logic        clock_i = 0, reset_i = 1, detector_raise_i = 0, detector_lower_i = 0;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, en, e;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q, w, seed = 32'h54ee_820a;
    logic [13:0] c, cnt;
    logic [2:0]  dly;
    logic [1:0]  grd;
    logic        lvl;
    int          num_errors = 0, checks_done = 0, cycles = 0;
    initial forever #2.5 clock_i = ~clock_i;
    dfc_detector_exact_config u_dut
    (
        .clock_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .detector_raise_i, .detector_lower_i,
        .detector_reset_delay_select_o(dly), .pump_raise_o(), .pump_lower_o(), .cycle_slip_guard_select_o(grd),
        .lock_or_readback_pin_level_o(lvl), .exact_mode_channel_count_o(cnt), .exact_mode_enable_o(en)
    );
    dfc_host_model u_host
    (
        .clock_i, .ack_i(wb_ack_o), .err_i(wb_err_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
        .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i)
    );
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic defaults();
        u_host.xfer(1'b0, ADDR_PHASE_DETECTOR, '0, q, e);
        chk(q, 32'h000F_8061);
        u_host.xfer(1'b0, ADDR_EXACT_FREQUENCY, '0, q, e);
        chk(q, 32'h0000_0000);
        chk({18'h0, cnt}, {8'h00, RESET_EXACT_FREQUENCY});
        chk({29'h0, dly}, {29'h0, RESET_PHASE_DETECTOR[PD_DELAY_MSB:PD_DELAY_LSB]});
        chk({31'h0, en}, 32'h0);
    endtask
    always @(posedge clock_i)
    begin
        {detector_raise_i, detector_lower_i} <= 2'($random(seed));
        if (++cycles > 4000)
        begin
            num_errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        defaults();
        for (int i = 0; i < 40; i++)
        begin
            w = u_host.legal($random(seed));
            u_host.xfer(1'b1, ADDR_PHASE_DETECTOR, w, q, e);
            u_host.xfer(1'b0, ADDR_PHASE_DETECTOR, '0, q, e);
            chk(q, w);
            chk({29'h0, dly}, {29'h0, w[PD_DELAY_MSB:PD_DELAY_LSB]});
            chk({30'h0, grd}, {30'h0, w[PD_GUARD_MSB:PD_GUARD_LSB]});
            chk({31'h0, lvl}, {31'h0, w[PD_PIN_LEVEL_BIT]});
            c = (i == 3) ? 14'h3FFF : (i < 3) ? 14'(i) : 14'($random(seed));
            u_host.xfer(1'b1, ADDR_EXACT_FREQUENCY, {18'h0, c}, q, e);
            u_host.xfer(1'b0, ADDR_EXACT_FREQUENCY, '0, q, e);
            chk(q, {18'h0, c});
            chk({18'h0, cnt}, {18'h0, c});
            chk({31'h0, en}, {31'h0, c > 14'h0001});
        end
        u_host.xfer(1'b0, 10'h034, '0, q, e);
        chk({31'h0, e}, 32'h1);
        // unmapped write answers with err and leaves the stored word alone
        u_host.xfer(1'b1, 10'h034, 32'hFFFF_FFFF, q, e);
        chk({31'h0, e}, 32'h1);
        u_host.xfer(1'b0, ADDR_PHASE_DETECTOR, '0, q, e);
        chk(q, w);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        defaults();
        complete_run();
    end
endmodule
`default_nettype wire
